// *** dv/ssfd_datapath_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "ssfd_regs.svh"

module ssfd_datapath_tb_top;
    typedef struct {
        logic [15:0] rd, aux, bc;
        logic [3:0] fl;
        logic [9:0] ctrl, mode;
        logic [7:0] port;
        logic so, err;
    } ssfd_note_t;
    logic sys_clk, rst, op_valid, op_three, serial_in, serial_out_q, op_error_q;
    ssfd_pkg::ssfd_op_t op_kind;
    ssfd_pkg::ssfd_shsrc_t shift_src_r, shift_src_q;
    logic [5:0] op_dest, op_src1, op_src2, rd_sel;
    logic [15:0] op_imm, rd_data_q, aux_q, block_counter_q, t;
    logic [15:0] rf [32];
    logic [9:0] op_mask, datapath_control_q, operating_mode_q;
    logic [7:0] port_direction_q, port_oe_n_q;
    logic zero_flag_q, carry_flag_q, sign_flag_q, ovf_flag_q, fifo_reset_q, interrupt_mode_bit_q;
    logic [31:0] lfsr = 32'h00012b2a;
    int mismatches = 0;
    int tests_run = 0;
    int i;
    ssfd_note_t m, n;
    ssfd_note_t notes[$];

    ssfd_datapath uut (.sys_clk(sys_clk), .rst(rst), .op_valid(op_valid), .op_kind(op_kind),
        .op_three(op_three), .op_dest(op_dest), .op_src1(op_src1), .op_src2(op_src2), .op_imm(op_imm),
        .shift_src_r(shift_src_r), .shift_src_q(shift_src_q), .op_mask(op_mask), .serial_in(serial_in),
        .rd_sel(rd_sel), .rd_data_q(rd_data_q), .aux_q(aux_q), .block_counter_q(block_counter_q),
        .zero_flag_q(zero_flag_q), .carry_flag_q(carry_flag_q), .sign_flag_q(sign_flag_q),
        .ovf_flag_q(ovf_flag_q), .datapath_control_q(datapath_control_q),
        .port_direction_q(port_direction_q), .port_oe_n_q(port_oe_n_q), .operating_mode_q(operating_mode_q),
        .fifo_reset_q(fifo_reset_q), .interrupt_mode_bit_q(interrupt_mode_bit_q),
        .serial_out_q(serial_out_q), .op_error_q(op_error_q));

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] rnd();
        repeat (16) lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr[15:0];
    endfunction

    function automatic logic [15:0] val(logic [5:0] s, logic [15:0] im);
        if (s < 6'h20) return rf[s[4:0]];
        if (s == `SSFD_SEL_AUX) return m.aux;
        if (s == `SSFD_SEL_BC) return m.bc;
        return im;
    endfunction

    function automatic logic gq(logic [5:0] s);
        return s <= `SSFD_SEL_AUX;
    endfunction

    // Codes follow the shift-source enum order
    function automatic logic pick(int c, logic [15:0] own, logic [15:0] oth, logic lf);
        case (c)
            0: return m.fl[3];
            1: return m.fl[2];
            2: return m.fl[1];
            3: return 1'b0;
            4: return 1'b1;
            5: return lf ? own[15] : own[0];
            6: return lf ? oth[15] : oth[0];
            default: return serial_in;
        endcase
    endfunction

    task automatic cmp_w(string nm, logic [15:0] e, logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

////////////////////////////////////////////////////////////////////////////////
    // Op code numbers follow the operation enum order; 0 means idle cycle
    task automatic go(int ko, logic th, logic [5:0] d, logic [5:0] s1, logic [5:0] s2, logic [15:0] im,
                      int sr, int sq, logic [9:0] mk, logic [5:0] rs);
        logic [15:0] a, b, r, q;
        logic [16:0] w;
        logic bad, lf;
        @(negedge sys_clk);
        a = rnd();
        op_valid = ko > 0;
        op_kind = ssfd_pkg::ssfd_op_t'(ko[3:0]);
        op_three = th;
        op_dest = d;
        op_src1 = s1;
        op_src2 = s2;
        op_imm = im;
        shift_src_r = ssfd_pkg::ssfd_shsrc_t'(sr[2:0]);
        shift_src_q = ssfd_pkg::ssfd_shsrc_t'(sq[2:0]);
        op_mask = mk;
        serial_in = a[0];
        rd_sel = rs;
        m.rd = val(rs, im);
        bad = 1'b0;
        lf = ko == 3 || ko == 4;
        if (ko == 1 || ko == 2) begin
            a = val(th ? s1 : d, im);
            b = val(th ? s2 : s1, im);
            if (th) bad = !(gq(s1) || gq(s2)) || (s1 < 6'h20 && s1 == s2)
                || (d < 6'h20 && s1 < 6'h20 && s2 < 6'h20 && d != s1 && d != s2 && s1 != s2);
            else bad = !(gq(d) || gq(s1));
            bad = bad || d > `SSFD_SEL_BC;
            w = {1'b0, a} - {1'b0, b} - {16'h0, ko == 2 && !m.fl[2]};
            if (!bad && d < 6'h20) rf[d[4:0]] = w[15:0];
            if (!bad && d == `SSFD_SEL_AUX) m.aux = w[15:0];
            if (!bad && d == `SSFD_SEL_BC) m.bc = w[15:0];
            if (!bad) m.fl = {w[15:0] == 16'h0, !w[16], w[15], a[15] != b[15] && w[15] != a[15]};
        end else if (ko >= 3 && ko <= 6) begin
            bad = d > 6'h1f;
            a = rf[d[4:0]];
            r = lf ? {a[14:0], pick(sr, a, m.aux, lf)} : {pick(sr, a, m.aux, lf), a[15:1]};
            q = lf ? {m.aux[14:0], pick(sq, m.aux, a, lf)} : {pick(sq, m.aux, a, lf), m.aux[15:1]};
            if (!bad && ko % 2 == 0) m.aux = q;
            if (!bad && (sr == 7 || (ko % 2 == 0 && sq == 7))) m.so = lf ? a[15] : a[0];
            if (!bad) rf[d[4:0]] = r;
            if (!bad) m.fl = {r == 16'h0, lf ? a[15] : a[0], r[15], a[15] != r[15]};
        end else if (ko >= 7 && ko < 9) m.ctrl = ko == 7 ? m.ctrl | mk : m.ctrl & ~mk;
        else if (ko >= 9 && ko < 11) m.port = ko == 9 ? m.port | mk[7:0] : m.port & ~mk[7:0];
        else if (ko >= 11) m.mode = ko == 11 ? m.mode | mk : m.mode & ~mk;
        if (ko > 0) m.err = bad;
        notes.push_back(m);
    endtask

    task automatic sub(int ko, logic th, logic [5:0] d, logic [5:0] s1, logic [5:0] s2, logic [15:0] im);
        go(ko, th, d, s1, s2, im, 3, 3, 10'h0, d);
    endtask

    // Registers start from known model state, so a subtract loads any value
    task automatic ld(logic [5:0] d, logic [15:0] v);
        sub(1, 1'b0, d, `SSFD_SEL_IMM, 6'h0, val(d, 16'h0) - v);
    endtask

////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever begin
            @(posedge sys_clk);
            #1;
            if (notes.size() > 0) begin
                n = notes.pop_front();
                cmp_w("rd_data", n.rd, rd_data_q);
                cmp_w("aux", n.aux, aux_q);
                cmp_w("block_counter", n.bc, block_counter_q);
                cmp_w("flags", {12'h0, n.fl}, {12'h0, zero_flag_q, carry_flag_q, sign_flag_q, ovf_flag_q});
                cmp_w("control", {6'h0, n.ctrl}, {6'h0, datapath_control_q});
                cmp_w("port_dir", {8'h0, n.port}, {8'h0, port_direction_q});
                cmp_w("port_oe_n", {8'h0, ~n.port}, {8'h0, port_oe_n_q});
                cmp_w("mode", {6'h0, n.mode}, {6'h0, operating_mode_q});
                cmp_w("mode_outs", {14'h0, n.mode[9], n.mode[0]}, {14'h0, fifo_reset_q, interrupt_mode_bit_q});
                cmp_w("serial_out", {15'h0, n.so}, {15'h0, serial_out_q});
                cmp_w("op_error", {15'h0, n.err}, {15'h0, op_error_q});
            end
        end
    end

    initial begin
        rst = 1'b1;
        op_valid = 1'b0;
        op_kind = ssfd_pkg::SSFD_NOP;
        op_three = 1'b0;
        {op_dest, op_src1, op_src2, rd_sel} = 24'h0;
        op_imm = 16'h0;
        shift_src_r = ssfd_pkg::SSFD_SRC_CONST0;
        shift_src_q = ssfd_pkg::SSFD_SRC_CONST0;
        op_mask = 10'h0;
        serial_in = 1'b0;
        m = '{default: '0};
        foreach (rf[k]) rf[k] = 16'h0;
        repeat (5) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        go(0, 1'b0, 6'h0, 6'h0, 6'h0, 16'h0, 3, 3, 10'h0, 6'h20);
        for (i = 1; i < 5; i++) ld(i[5:0], rnd());
        ld(`SSFD_SEL_AUX, rnd());
        sub(1, 1'b1, 6'h5, 6'h1, 6'h2, 16'h0);
        sub(1, 1'b1, `SSFD_SEL_BC, 6'h3, 6'h4, 16'h0);
        sub(1, 1'b0, 6'h6, `SSFD_SEL_IMM, 6'h0, 16'h1);
        sub(2, 1'b0, 6'h6, `SSFD_SEL_IMM, 6'h0, 16'h0);
        sub(2, 1'b0, 6'h6, `SSFD_SEL_IMM, 6'h0, 16'h0);
        sub(2, 1'b0, `SSFD_SEL_BC, 6'h6, 6'h0, 16'h0);
        sub(2, 1'b1, `SSFD_SEL_BC, 6'h1, 6'h2, 16'h0);
        ld(6'h7, 16'h8000);
        sub(1, 1'b0, 6'h7, `SSFD_SEL_IMM, 6'h0, 16'h1);
        sub(1, 1'b0, 6'h1, 6'h1, 6'h0, 16'h0);
        // Refused forms first, then a legal one clears the error
        sub(1, 1'b0, `SSFD_SEL_IMM, `SSFD_SEL_BC, 6'h0, 16'h5);
        sub(2, 1'b0, `SSFD_SEL_BC, `SSFD_SEL_IMM, 6'h0, 16'h5);
        sub(1, 1'b1, 6'h8, `SSFD_SEL_BC, `SSFD_SEL_IMM, 16'h5);
        sub(1, 1'b1, 6'h8, 6'h1, 6'h1, 16'h0);
        sub(1, 1'b1, 6'h8, 6'h1, 6'h2, 16'h0);
        go(3, 1'b0, `SSFD_SEL_AUX, 6'h0, 6'h0, 16'h0, 4, 4, 10'h0, 6'h8);
        sub(1, 1'b1, 6'h8, 6'h8, 6'h2, 16'h0);
        for (i = 0; i < 32; i++) begin
            if (i % 4 == 0) ld(6'h9, rnd());
            go(3 + i / 8, 1'b0, 6'h9, 6'h0, 6'h0, 16'h0, i % 8, (i + 3) % 7, 10'h0, 6'h9);
        end
        go(7, 1'b0, 6'h0, 6'h0, 6'h0, 16'h0, 3, 3, 10'h003, 6'h9);
        go(7, 1'b0, 6'h0, 6'h0, 6'h0, 16'h0, 3, 3, 10'h3ff, 6'h9);
        go(8, 1'b0, 6'h0, 6'h0, 6'h0, 16'h0, 3, 3, 10'h003, 6'h9);
        go(9, 1'b0, 6'h0, 6'h0, 6'h0, 16'h0, 3, 3, 10'h0ff, 6'h9);
        go(11, 1'b0, 6'h0, 6'h0, 6'h0, 16'h0, 3, 3, 10'h200, 6'h9);
        go(12, 1'b0, 6'h0, 6'h0, 6'h0, 16'h0, 3, 3, 10'h200, 6'h9);
        go(11, 1'b0, 6'h0, 6'h0, 6'h0, 16'h0, 3, 3, 10'h001, 6'h9);
        for (i = 0; i < 18; i++) begin
            t = rnd();
            go(7 + i % 6, 1'b0, 6'h0, 6'h0, 6'h0, 16'h0, 3, 3, t[9:0], 6'h9);
        end
        for (i = 0; i < 80; i++) begin
            t = rnd();
            go(int'(t % 12) + 1, t[15], 6'(rnd() % 35), 6'(rnd() % 35), 6'(rnd() % 35), rnd(),
               int'(t[14:12]), int'(rnd() % 8), t[9:0], 6'(rnd() % 35));
        end
        for (i = 0; i < 8 && notes.size() > 0; i++) @(negedge sys_clk);
        if (notes.size() > 0) mismatches++;
        end_sim();
    end
endmodule // ssfd_datapath_tb_top
`default_nettype wire

// *** pkg/ssfd_pkg.sv ***
package ssfd_pkg;

    typedef enum logic [3:0] {
        SSFD_NOP,
        SSFD_SUB,
        SSFD_BORROW_DIFFERENCE_OP,
        SSFD_LEFT_SHIFT_OP,
        SSFD_LEFT_SHIFT_PAIR_OP,
        SSFD_RIGHT_SHIFT_OP,
        SSFD_RIGHT_SHIFT_PAIR_OP,
        SSFD_CTRL_BITS_SET_OP,
        SSFD_CTRL_BITS_CLEAR_OP,
        SSFD_PORT_DIR_SET_OP,
        SSFD_PORT_DIR_CLEAR_OP,
        SSFD_MODE_BITS_SET_OP,
        SSFD_MODE_BITS_CLEAR_OP
    } ssfd_op_t;

    typedef enum logic [2:0] {
        SSFD_SRC_ZERO_FLAG,
        SSFD_SRC_CARRY_FLAG,
        SSFD_SRC_SIGN_FLAG,
        SSFD_SRC_CONST0,
        SSFD_SRC_CONST1,
        SSFD_SRC_OWN_END,
        SSFD_SRC_AUX_END,
        SSFD_SRC_SERIAL_PIN
    } ssfd_shsrc_t;

endpackage

// *** pkg/ssfd_regs.svh ***
`ifndef SSFD_REGS_SVH
`define SSFD_REGS_SVH

`define SSFD_DATA_W 16
`define SSFD_NUM_REGS 32
`define SSFD_SEL_W 6
`define SSFD_CTRL_W 10
`define SSFD_PORT_W 8
`define SSFD_MODE_W 10

// Operand select codes: 0..31 are the general registers
`define SSFD_SEL_AUX 6'h20
`define SSFD_SEL_BC 6'h21
`define SSFD_SEL_IMM 6'h22

// Field positions
`define SSFD_CTRL_ADDR_COUNT_EN 0
`define SSFD_CTRL_BLOCK_COUNT_EN 1
`define SSFD_MODE_INTERRUPT 0
`define SSFD_MODE_FIFO_RESET 9

// Reset values
`define SSFD_CTRL_RESET 10'h000
`define SSFD_PORT_RESET 8'h00
`define SSFD_MODE_RESET 10'h000
`define SSFD_DATA_RESET 16'h0000

`endif

// *** verilog/ssfd_datapath.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "ssfd_regs.svh"

module ssfd_datapath #(
    parameter int DATA_W = `SSFD_DATA_W,
    parameter int NUM_REGS = `SSFD_NUM_REGS
) (
    input wire logic sys_clk, // 25 MHz instruction clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic op_valid, // One instruction this cycle
    input wire ssfd_pkg::ssfd_op_t op_kind, // Operation
    input wire logic op_three, // Subtract uses three operands
    input wire logic [`SSFD_SEL_W-1:0] op_dest, // Destination or dest/src
    input wire logic [`SSFD_SEL_W-1:0] op_src1, // Source (first source)
    input wire logic [`SSFD_SEL_W-1:0] op_src2, // Second source
    input wire logic [DATA_W-1:0] op_imm, // Immediate constant
    input wire ssfd_pkg::ssfd_shsrc_t shift_src_r, // Shift-in for register
    input wire ssfd_pkg::ssfd_shsrc_t shift_src_q, // Shift-in for aux
    input wire logic [`SSFD_CTRL_W-1:0] op_mask, // Set/clear mask
    input wire logic serial_in, // Serial data pin level
    input wire logic [`SSFD_SEL_W-1:0] rd_sel, // Readback select
    output logic [DATA_W-1:0] rd_data_q, // Readback data
    output logic [DATA_W-1:0] aux_q, // Auxiliary register
    output logic [DATA_W-1:0] block_counter_q, // Block counter
    output logic zero_flag_q, // Zero flag
    output logic carry_flag_q, // Carry flag, set means no borrow
    output logic sign_flag_q, // Sign flag
    output logic ovf_flag_q, // Overflow flag
    output logic [`SSFD_CTRL_W-1:0] datapath_control_q, // Control register
    output logic [`SSFD_PORT_W-1:0] port_direction_q, // Port direction
    output logic [`SSFD_PORT_W-1:0] port_oe_n_q, // Port drive enable, low
    output logic [`SSFD_MODE_W-1:0] operating_mode_q, // Mode register
    output logic fifo_reset_q, // FIFO held in reset
    output logic interrupt_mode_bit_q, // Interrupt mode on
    output logic serial_out_q, // Bit shifted toward serial pin
    output logic op_error_q // Last operation refused
);

    ////////////////////////////////////////////////////////////////////////
    // Operand decode

    function automatic logic is_gpr(input logic [`SSFD_SEL_W-1:0] sel);
        is_gpr = (sel < `SSFD_SEL_AUX);
    endfunction

    function automatic logic is_gpr_or_aux(input logic [`SSFD_SEL_W-1:0] sel);
        is_gpr_or_aux = is_gpr(sel) || (sel == `SSFD_SEL_AUX);
    endfunction

    function automatic logic is_writable(input logic [`SSFD_SEL_W-1:0] sel);
        is_writable = is_gpr_or_aux(sel) || (sel == `SSFD_SEL_BC);
    endfunction

    logic [DATA_W-1:0] gpr_q [NUM_REGS];

    function automatic logic [DATA_W-1:0] read_opnd(input logic [`SSFD_SEL_W-1:0] sel);
        if (is_gpr(sel)) begin
            read_opnd = gpr_q[sel[4:0]];
        end else if (sel == `SSFD_SEL_AUX) begin
            read_opnd = aux_q;
        end else if (sel == `SSFD_SEL_BC) begin
            read_opnd = block_counter_q;
        end else begin
            read_opnd = op_imm;
        end
    endfunction

    wire logic is_sub = (op_kind == ssfd_pkg::SSFD_SUB) || (op_kind == ssfd_pkg::SSFD_BORROW_DIFFERENCE_OP);
    wire logic is_sbc = (op_kind == ssfd_pkg::SSFD_BORROW_DIFFERENCE_OP);
    wire logic is_left = (op_kind == ssfd_pkg::SSFD_LEFT_SHIFT_OP) || (op_kind == ssfd_pkg::SSFD_LEFT_SHIFT_PAIR_OP);
    wire logic is_right = (op_kind == ssfd_pkg::SSFD_RIGHT_SHIFT_OP) ||
                          (op_kind == ssfd_pkg::SSFD_RIGHT_SHIFT_PAIR_OP);
    wire logic is_pair = (op_kind == ssfd_pkg::SSFD_LEFT_SHIFT_PAIR_OP) ||
                         (op_kind == ssfd_pkg::SSFD_RIGHT_SHIFT_PAIR_OP);
    wire logic is_shift = is_left || is_right;
    wire logic is_mask = (op_kind >= ssfd_pkg::SSFD_CTRL_BITS_SET_OP) &&
                         (op_kind <= ssfd_pkg::SSFD_MODE_BITS_CLEAR_OP);

    ////////////////////////////////////////////////////////////////////////
    // Operand legality

    wire logic legal_sub2 = is_writable(op_dest) &&
                            (is_gpr_or_aux(op_dest) || is_gpr_or_aux(op_src1));
    wire logic src_has_reg = is_gpr_or_aux(op_src1) || is_gpr_or_aux(op_src2);
    wire logic same_src = is_gpr(op_src1) && is_gpr(op_src2) && (op_src1 == op_src2);
    wire logic three_gprs = is_gpr(op_dest) && is_gpr(op_src1) && is_gpr(op_src2) &&
                            (op_dest != op_src1) && (op_dest != op_src2);
    wire logic legal_sub3 = is_writable(op_dest) && src_has_reg && !same_src && !three_gprs;
    wire logic legal_sub = op_three ? legal_sub3 : legal_sub2;
    wire logic legal_shift = is_gpr(op_dest);
    wire logic op_legal = is_mask || (op_kind == ssfd_pkg::SSFD_NOP) ||
                          (is_sub && legal_sub) || (is_shift && legal_shift);
    wire logic op_go = op_valid && op_legal;

    ////////////////////////////////////////////////////////////////////////
    // Subtract

    // Blocks, not assigns: the operand function reads registers that are not its arguments
    logic [DATA_W-1:0] src_a, src_b;
    always_comb begin
        // Two-operand form reads its first operand from the destination
        src_a = op_three ? read_opnd(op_src1) : read_opnd(op_dest);
        src_b = op_three ? read_opnd(op_src2) : read_opnd(op_src1);
    end
    // Carry set means no borrow, so on the borrow-difference op a clear carry takes one more away
    wire logic borrow_in = is_sbc && !carry_flag_q;
    wire logic [DATA_W:0] diff_wide = {1'b0, src_a} - {1'b0, src_b} - {{DATA_W{1'b0}}, borrow_in};
    wire logic [DATA_W-1:0] sub_res = diff_wide[DATA_W-1:0];
    wire logic sub_cy = !diff_wide[DATA_W];
    wire logic sub_ovf = (src_a[DATA_W-1] != src_b[DATA_W-1]) && (sub_res[DATA_W-1] != src_a[DATA_W-1]);

    ////////////////////////////////////////////////////////////////////////
    // Shift

    function automatic logic pick_bit(input ssfd_pkg::ssfd_shsrc_t src, input logic own, input logic aux);
        case (src)
            ssfd_pkg::SSFD_SRC_ZERO_FLAG: pick_bit = zero_flag_q;
            ssfd_pkg::SSFD_SRC_CARRY_FLAG: pick_bit = carry_flag_q;
            ssfd_pkg::SSFD_SRC_SIGN_FLAG: pick_bit = sign_flag_q;
            ssfd_pkg::SSFD_SRC_CONST0: pick_bit = 1'b0;
            ssfd_pkg::SSFD_SRC_CONST1: pick_bit = 1'b1;
            ssfd_pkg::SSFD_SRC_OWN_END: pick_bit = own;
            ssfd_pkg::SSFD_SRC_AUX_END: pick_bit = aux;
            ssfd_pkg::SSFD_SRC_SERIAL_PIN: pick_bit = serial_in;
            default: pick_bit = 1'b0;
        endcase
    endfunction

    logic [DATA_W-1:0] sh_reg;
    logic reg_end, aux_end, bit_r, bit_q;
    // Flags and registers read inside the functions must wake this block
    always_comb begin
        sh_reg = read_opnd(op_dest);
        // End bit leaving each register: MSB going left, LSB going right
        reg_end = is_left ? sh_reg[DATA_W-1] : sh_reg[0];
        aux_end = is_left ? aux_q[DATA_W-1] : aux_q[0];
        bit_r = pick_bit(shift_src_r, reg_end, aux_end);
        bit_q = pick_bit(shift_src_q, aux_end, reg_end);
    end
    wire logic [DATA_W-1:0] sh_r_res = is_left ? {sh_reg[DATA_W-2:0], bit_r} :
                                                 {bit_r, sh_reg[DATA_W-1:1]};
    wire logic [DATA_W-1:0] sh_q_res = is_left ? {aux_q[DATA_W-2:0], bit_q} :
                                                 {bit_q, aux_q[DATA_W-1:1]};
    wire logic sh_ovf = (sh_r_res[DATA_W-1] != sh_reg[DATA_W-1]);
    wire logic uses_serial = (shift_src_r == ssfd_pkg::SSFD_SRC_SERIAL_PIN) ||
                             (is_pair && (shift_src_q == ssfd_pkg::SSFD_SRC_SERIAL_PIN));

    ////////////////////////////////////////////////////////////////////////
    // Writeback select

    wire logic [DATA_W-1:0] wr_data = is_sub ? sub_res : sh_r_res;
    wire logic wr_any = op_go && (is_sub || is_shift);
    wire logic gpr_we = wr_any && is_gpr(op_dest);
    wire logic aux_we = (wr_any && (op_dest == `SSFD_SEL_AUX)) || (op_go && is_pair);
    wire logic [DATA_W-1:0] aux_d = (is_shift && is_pair) ? sh_q_res : wr_data;
    wire logic bc_we = wr_any && (op_dest == `SSFD_SEL_BC);
    wire logic flags_we = wr_any;
    wire logic z_d = (wr_data == {DATA_W{1'b0}});
    wire logic cy_d = is_sub ? sub_cy : reg_end;
    wire logic s_d = wr_data[DATA_W-1];
    wire logic o_d = is_sub ? sub_ovf : sh_ovf;

    // Mask operations: set wins only for its own register
    wire logic [`SSFD_CTRL_W-1:0] ctrl_d =
        (op_go && op_kind == ssfd_pkg::SSFD_CTRL_BITS_SET_OP) ? (datapath_control_q | op_mask) :
        (op_go && op_kind == ssfd_pkg::SSFD_CTRL_BITS_CLEAR_OP) ? (datapath_control_q & ~op_mask) :
        datapath_control_q;
    wire logic [`SSFD_PORT_W-1:0] port_d =
        (op_go && op_kind == ssfd_pkg::SSFD_PORT_DIR_SET_OP) ? (port_direction_q | op_mask[`SSFD_PORT_W-1:0]) :
        (op_go && op_kind == ssfd_pkg::SSFD_PORT_DIR_CLEAR_OP) ? (port_direction_q & ~op_mask[`SSFD_PORT_W-1:0]) :
        port_direction_q;
    wire logic [`SSFD_MODE_W-1:0] mode_d =
        (op_go && op_kind == ssfd_pkg::SSFD_MODE_BITS_SET_OP) ? (operating_mode_q | op_mask) :
        (op_go && op_kind == ssfd_pkg::SSFD_MODE_BITS_CLEAR_OP) ? (operating_mode_q & ~op_mask) :
        operating_mode_q;

    ////////////////////////////////////////////////////////////////////////
    // Register file

    genvar gi;
    generate
        for (gi = 0; gi < NUM_REGS; gi++) begin : g_gpr
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    gpr_q[gi] <= `SSFD_DATA_RESET;
                end else if (gpr_we && (op_dest[4:0] == 5'(gi))) begin
                    gpr_q[gi] <= wr_data;
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            aux_q <= `SSFD_DATA_RESET;
            block_counter_q <= `SSFD_DATA_RESET;
        end else begin
            if (aux_we) begin
                aux_q <= aux_d;
            end
            if (bc_we) begin
                block_counter_q <= wr_data;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            zero_flag_q <= 1'b0;
            carry_flag_q <= 1'b0;
            sign_flag_q <= 1'b0;
            ovf_flag_q <= 1'b0;
        end else if (flags_we) begin
            zero_flag_q <= z_d;
            carry_flag_q <= cy_d;
            sign_flag_q <= s_d;
            ovf_flag_q <= o_d;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            datapath_control_q <= `SSFD_CTRL_RESET;
            port_direction_q <= `SSFD_PORT_RESET;
            port_oe_n_q <= ~`SSFD_PORT_RESET;
            operating_mode_q <= `SSFD_MODE_RESET;
            fifo_reset_q <= 1'b0;
            interrupt_mode_bit_q <= 1'b0;
        end else begin
            datapath_control_q <= ctrl_d;
            port_direction_q <= port_d;
            port_oe_n_q <= ~port_d;
            operating_mode_q <= mode_d;
            // Held until software clears it; no self-clear here
            fifo_reset_q <= mode_d[`SSFD_MODE_FIFO_RESET];
            interrupt_mode_bit_q <= mode_d[`SSFD_MODE_INTERRUPT];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            serial_out_q <= 1'b0;
            op_error_q <= 1'b0;
            rd_data_q <= `SSFD_DATA_RESET;
        end else begin
            if (op_go && is_shift && uses_serial) begin
                serial_out_q <= reg_end;
            end
            if (op_valid) begin
                op_error_q <= !op_legal;
            end
            // Readback lags one cycle, so it shows state before this edge
            rd_data_q <= read_opnd(rd_sel);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_ctrl_set_mask: assert property (
        op_valid && op_kind == ssfd_pkg::SSFD_CTRL_BITS_SET_OP |=>
            datapath_control_q == ($past(datapath_control_q) | $past(op_mask)))
        else $error("control set mask wrong");

    a_ctrl_clear_mask: assert property (
        op_valid && op_kind == ssfd_pkg::SSFD_CTRL_BITS_CLEAR_OP |=>
            datapath_control_q == ($past(datapath_control_q) & ~$past(op_mask)))
        else $error("control clear mask wrong");

    a_port_dir_oe: assert property (
        op_valid && op_kind == ssfd_pkg::SSFD_PORT_DIR_SET_OP |=>
            ((port_direction_q & $past(op_mask[`SSFD_PORT_W-1:0])) == $past(op_mask[`SSFD_PORT_W-1:0])) &&
            (port_oe_n_q == ~port_direction_q))
        else $error("port direction set wrong");

    a_mode_set_mask: assert property (
        op_valid && op_kind == ssfd_pkg::SSFD_MODE_BITS_SET_OP |=>
            operating_mode_q == ($past(operating_mode_q) | $past(op_mask)))
        else $error("mode set mask wrong");

    a_mode_bit_outputs: assert property (
        ##1 (fifo_reset_q == operating_mode_q[`SSFD_MODE_FIFO_RESET]) &&
            (interrupt_mode_bit_q == operating_mode_q[`SSFD_MODE_INTERRUPT]))
        else $error("mode bit outputs disagree");

    a_mask_flags_keep: assert property (
        op_valid && is_mask |=> $stable(zero_flag_q) && $stable(carry_flag_q) &&
            $stable(sign_flag_q) && $stable(ovf_flag_q))
        else $error("mask op changed flags");

    a_sbc_borrow_dec: assert property (
        op_valid && is_sbc && !carry_flag_q |-> sub_res == (src_a - src_b - 16'h0001))
        else $error("borrow not taken");

    a_sub_bc_write: assert property (
        op_valid && is_sub && legal_sub && op_dest == `SSFD_SEL_BC |=>
            block_counter_q == $past(src_a - src_b - {15'h0000, is_sbc && !carry_flag_q}) &&
            zero_flag_q == (block_counter_q == 16'h0000))
        else $error("subtract into block counter wrong");

    a_illegal_refused: assert property (
        op_valid && is_sub && op_three && same_src |=>
            op_error_q && $stable(block_counter_q) && $stable(carry_flag_q))
        else $error("illegal subtract not refused");

    a_rotate_left: assert property (
        op_valid && op_kind == ssfd_pkg::SSFD_LEFT_SHIFT_OP && shift_src_r == ssfd_pkg::SSFD_SRC_OWN_END |->
            sh_r_res == {sh_reg[DATA_W-2:0], sh_reg[DATA_W-1]})
        else $error("left rotate wrong");

    a_shift_carry_out: assert property (
        op_valid && is_shift && legal_shift |=> carry_flag_q == $past(reg_end) &&
            sign_flag_q == $past(sh_r_res[DATA_W-1]))
        else $error("shift flags wrong");

    a_pair_aux_shift: assert property (
        op_valid && op_kind == ssfd_pkg::SSFD_RIGHT_SHIFT_PAIR_OP && legal_shift |=>
            aux_q[DATA_W-2:0] == $past(aux_q[DATA_W-1:1]))
        else $error("paired aux shift wrong");

    a_sub_three_write: assert property (
        op_valid && op_kind == ssfd_pkg::SSFD_SUB && op_three && legal_sub && is_gpr(op_dest) |=>
            gpr_q[$past(op_dest[4:0])] == $past(src_a) - $past(src_b))
        else $error("three-operand subtract wrong");

    a_right_shift_msb: assert property (
        op_valid && op_kind == ssfd_pkg::SSFD_RIGHT_SHIFT_OP && legal_shift |=>
            gpr_q[$past(op_dest[4:0])] == {$past(bit_r), $past(sh_reg[DATA_W-1:1])})
        else $error("right shift wrong");

    a_ctrl_enable_bits: assert property (
        op_valid && op_kind == ssfd_pkg::SSFD_CTRL_BITS_CLEAR_OP && op_mask == 10'h003 |=>
            datapath_control_q[`SSFD_CTRL_BLOCK_COUNT_EN:`SSFD_CTRL_ADDR_COUNT_EN] == 2'h0 &&
            datapath_control_q[`SSFD_CTRL_W-1:2] == $past(datapath_control_q[`SSFD_CTRL_W-1:2]))
        else $error("enable bits clear wrong");

    c_sub_three: cover property (op_valid && is_sub && op_three && legal_sub);
    c_sbc_borrow: cover property (op_valid && is_sbc && !carry_flag_q && legal_sub);
    c_rotate: cover property (op_valid && is_left && shift_src_r == ssfd_pkg::SSFD_SRC_OWN_END && legal_shift);
    c_pair_serial: cover property (op_valid && is_pair && uses_serial && legal_shift);
    c_fifo_reset: cover property (op_valid && op_kind == ssfd_pkg::SSFD_MODE_BITS_SET_OP && op_mask[9]);

endmodule // ssfd_datapath

`default_nettype wire
